// ===== dnco_pkg.sv
// Shared constants for the numerically controlled oscillator core
package dnco_pkg;
  localparam int ACC_W = 28;
  localparam int PH_W = 12;
  localparam int AMP_W = 10;
  localparam int PADDR_W = 8;
  localparam logic [PADDR_W-1:0] OFS_TUNE_A = 8'h00;
  localparam logic [PADDR_W-1:0] OFS_TUNE_B = 8'h04;
  localparam logic [PADDR_W-1:0] OFS_PHASE_A = 8'h08;
  localparam logic [PADDR_W-1:0] OFS_PHASE_B = 8'h0c;
  localparam logic [PADDR_W-1:0] OFS_CTRL = 8'h10;
  localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam int CTRL_W = 7;
  localparam int CB_FREQ_CHOICE = 0;
  localparam int CB_FREQ_USE_PIN = 1;
  localparam int CB_PHASE_CHOICE = 2;
  localparam int CB_PHASE_USE_PIN = 3;
  localparam int CB_WAVE_MODE = 4;
  localparam int CB_DIG_OUT_EN = 5;
  localparam int CB_CMP_ROUTE = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam logic [ACC_W-1:0] TUNE_RESET = 28'h0000000;
  localparam logic [PH_W-1:0] PHASE_RESET = 12'h000;
  localparam logic [AMP_W-1:0] MID_CODE = 10'h200;
  localparam int FIFO_DEPTH = 8;
endpackage

// ===== dnco_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module dnco_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [$clog2(DEPTH+1)-1:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count_r != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign level = count_r;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      // Pointer wrap assumes a power-of-two depth
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + {{($clog2(DEPTH+1)-1){1'b0}}, push}
                 - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
    end
  end
endmodule

// ===== dnco_core.sv
// Phase accumulator, phase offset, sine mapping and register slave
//
// Function
// - A 28-bit phase accumulator produces the waveform phase.
// - The accumulator wraps modulo 2^28, one full range being one waveform cycle.
// - The increment comes from one of two tuning words, chosen by a pin or a control bit.
// - Switching tuning words changes only the increment, never the accumulator value.
// - A 12-bit offset from the selected phase register is added to the accumulator top bits.
// - Two phase offset registers exist, each step being 1/4096 of a cycle.
// - The offset phase is truncated to 12 bits, which address the sine table.
// - The table returns 10-bit amplitude codes for the converter.
// - Waveform mode bit and digital output enable decide whether the sine table is used.
// - The comparator path is enabled only when route bit and output enable are both one.
// - The phase register is chosen by a phase select pin or a phase select control bit.
// - An active-high core reset clears the pipeline to a midscale output, sparing registers.
`timescale 1ns/10ps
module dnco_core (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pipeline reset and select pins
  input wire logic core_reset,
  input wire logic freq_choice_pin,
  input wire logic phase_choice_pin,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dnco_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter side
  output logic [dnco_pkg::AMP_W-1:0] dac_data,
  output logic dac_valid,
  input wire logic dac_ready,
  output logic msb_out,
  output logic comparator_enable
);
  localparam int FL_W = $clog2(dnco_pkg::FIFO_DEPTH + 1);

  logic [dnco_pkg::ACC_W-1:0] tuning_word_a_r;
  logic [dnco_pkg::ACC_W-1:0] tuning_word_b_r;
  logic [dnco_pkg::PH_W-1:0] phase_offset_a_r;
  logic [dnco_pkg::PH_W-1:0] phase_offset_b_r;
  logic [dnco_pkg::CTRL_W-1:0] ctrl_r;
  logic [dnco_pkg::ACC_W-1:0] acc_r;
  logic [dnco_pkg::PH_W-1:0] phase_r;
  logic phase_ok_r;
  logic [dnco_pkg::AMP_W-1:0] dac_data_r;
  logic dac_valid_r;
  logic msb_out_r;
  logic comparator_enable_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [dnco_pkg::AMP_W-1:0] fifo_out_data;
  logic [FL_W-1:0] fifo_level;

  // Register decode
  wire access = psel && penable && !pready_r;
  wire wr_done = psel && penable && pready_r && pwrite;
  wire hit_tune_a = (paddr == dnco_pkg::OFS_TUNE_A);
  wire hit_tune_b = (paddr == dnco_pkg::OFS_TUNE_B);
  wire hit_phase_a = (paddr == dnco_pkg::OFS_PHASE_A);
  wire hit_phase_b = (paddr == dnco_pkg::OFS_PHASE_B);
  wire hit_ctrl = (paddr == dnco_pkg::OFS_CTRL);
  wire hit_status = (paddr == dnco_pkg::OFS_STATUS);
  wire hit_any = hit_tune_a || hit_tune_b || hit_phase_a || hit_phase_b || hit_ctrl
                 || hit_status;
  wire [31:0] status_word = {{(32-FL_W-dnco_pkg::PH_W){1'b0}}, fifo_level,
                             acc_r[dnco_pkg::ACC_W-1 -: dnco_pkg::PH_W]};
  wire [31:0] rd_mux =
    hit_tune_a ? {{(32-dnco_pkg::ACC_W){1'b0}}, tuning_word_a_r} :
    hit_tune_b ? {{(32-dnco_pkg::ACC_W){1'b0}}, tuning_word_b_r} :
    hit_phase_a ? {{(32-dnco_pkg::PH_W){1'b0}}, phase_offset_a_r} :
    hit_phase_b ? {{(32-dnco_pkg::PH_W){1'b0}}, phase_offset_b_r} :
    hit_ctrl ? {{(32-dnco_pkg::CTRL_W){1'b0}}, ctrl_r} :
    hit_status ? status_word : 32'h0000_0000;

  // Source selection
  wire freq_sel = ctrl_r[dnco_pkg::CB_FREQ_USE_PIN] ? freq_choice_pin
                  : ctrl_r[dnco_pkg::CB_FREQ_CHOICE];
  wire phase_sel = ctrl_r[dnco_pkg::CB_PHASE_USE_PIN] ? phase_choice_pin
                   : ctrl_r[dnco_pkg::CB_PHASE_CHOICE];
  wire [dnco_pkg::ACC_W-1:0] step = freq_sel ? tuning_word_b_r : tuning_word_a_r;
  wire [dnco_pkg::PH_W-1:0] offset = phase_sel ? phase_offset_b_r : phase_offset_a_r;
  wire wave_ramp = ctrl_r[dnco_pkg::CB_WAVE_MODE];
  wire dig_en = ctrl_r[dnco_pkg::CB_DIG_OUT_EN];
  wire cmp_route = ctrl_r[dnco_pkg::CB_CMP_ROUTE];

  // Stall only when the converter refuses data long enough to fill the FIFO
  wire advance = fifo_in_ready;
  wire [dnco_pkg::ACC_W-1:0] acc_nxt = acc_r + step;
  wire [dnco_pkg::PH_W-1:0] phase_nxt =
    acc_r[dnco_pkg::ACC_W-1 -: dnco_pkg::PH_W] + offset;

  // Parabolic half-wave keeps the table free of stored constants
  wire [dnco_pkg::PH_W-2:0] half = phase_r[dnco_pkg::PH_W-2:0];
  wire [dnco_pkg::PH_W-1:0] half_rest = {1'b1, {(dnco_pkg::PH_W-1){1'b0}}} - {1'b0, half};
  wire [2*dnco_pkg::PH_W-1:0] prod = {{(dnco_pkg::PH_W+1){1'b0}}, half} * {12'h000, half_rest};
  // Peak product is 2^20, so bits 20:11 span the full half-scale swing
  wire [dnco_pkg::AMP_W-1:0] mag_raw =
    prod[dnco_pkg::PH_W+dnco_pkg::AMP_W-2 -: dnco_pkg::AMP_W];
  wire [dnco_pkg::AMP_W-2:0] mag = (mag_raw > {1'b0, {(dnco_pkg::AMP_W-1){1'b1}}})
                                   ? {(dnco_pkg::AMP_W-1){1'b1}} : mag_raw[dnco_pkg::AMP_W-2:0];
  wire [dnco_pkg::AMP_W-1:0] sine_code = phase_r[dnco_pkg::PH_W-1]
                                         ? dnco_pkg::MID_CODE - {1'b0, mag}
                                         : dnco_pkg::MID_CODE + {1'b0, mag};
  wire [dnco_pkg::AMP_W-1:0] ramp_code = phase_r[dnco_pkg::PH_W-1]
                                         ? ~phase_r[dnco_pkg::PH_W-2 -: dnco_pkg::AMP_W]
                                         : phase_r[dnco_pkg::PH_W-2 -: dnco_pkg::AMP_W];
  wire use_sine = !wave_ramp || dig_en;
  wire [dnco_pkg::AMP_W-1:0] amp_code = use_sine ? sine_code : ramp_code;
  wire take_out = fifo_out_valid && (!dac_valid_r || dac_ready);

  // APB slave, one wait state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= access;
      pslverr_r <= access && !hit_any;
      prdata_r <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Core reset leaves all of these alone
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tuning_word_a_r <= dnco_pkg::TUNE_RESET;
      tuning_word_b_r <= dnco_pkg::TUNE_RESET;
      phase_offset_a_r <= dnco_pkg::PHASE_RESET;
      phase_offset_b_r <= dnco_pkg::PHASE_RESET;
      ctrl_r <= dnco_pkg::CTRL_RESET;
    end
    else if (wr_done)
    begin
      if (hit_tune_a)
        tuning_word_a_r <= pwdata[dnco_pkg::ACC_W-1:0];
      if (hit_tune_b)
        tuning_word_b_r <= pwdata[dnco_pkg::ACC_W-1:0];
      if (hit_phase_a)
        phase_offset_a_r <= pwdata[dnco_pkg::PH_W-1:0];
      if (hit_phase_b)
        phase_offset_b_r <= pwdata[dnco_pkg::PH_W-1:0];
      if (hit_ctrl)
        ctrl_r <= pwdata[dnco_pkg::CTRL_W-1:0];
    end
  end

  // Accumulator and phase stage
  always_ff @(posedge clk)
  begin
    if (sys_rst || core_reset)
    begin
      acc_r <= '0;
      phase_r <= '0;
      phase_ok_r <= 1'b0;
    end
    else if (advance)
    begin
      acc_r <= acc_nxt;
      phase_r <= phase_nxt;
      phase_ok_r <= 1'b1;
    end
  end

  // Output stage
  always_ff @(posedge clk)
  begin
    if (sys_rst || core_reset)
    begin
      dac_data_r <= dnco_pkg::MID_CODE;
      dac_valid_r <= 1'b0;
      msb_out_r <= 1'b0;
      comparator_enable_r <= 1'b0;
    end
    else
    begin
      if (take_out)
        dac_data_r <= fifo_out_data;
      if (take_out || dac_ready)
        dac_valid_r <= fifo_out_valid;
      msb_out_r <= dig_en && !cmp_route && phase_r[dnco_pkg::PH_W-1];
      comparator_enable_r <= dig_en && cmp_route;
    end
  end

  dnco_fifo #(
    .WIDTH(dnco_pkg::AMP_W),
    .DEPTH(dnco_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .flush(sys_rst || core_reset),
    .in_valid(phase_ok_r),
    .in_ready(fifo_in_ready),
    .in_data(amp_code),
    .out_valid(fifo_out_valid),
    .out_ready(!dac_valid_r || dac_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dac_data = dac_data_r;
  assign dac_valid = dac_valid_r;
  assign msb_out = msb_out_r;
  assign comparator_enable = comparator_enable_r;

  // Checks
  wire run = !sys_rst && !core_reset;

  a_acc_step: assert property (@(posedge clk) disable iff (sys_rst)
    run && advance |=> core_reset || acc_r == $past(acc_r) + $past(step))
    else $error("accumulator did not add the selected step");
  a_acc_hold: assert property (@(posedge clk) disable iff (sys_rst)
    run && !advance |=> core_reset || $stable(acc_r))
    else $error("accumulator moved while stalled");
  a_step_select: assert property (@(posedge clk) disable iff (sys_rst)
    step == ((ctrl_r[1] ? freq_choice_pin : ctrl_r[0]) ? tuning_word_b_r : tuning_word_a_r))
    else $error("wrong tuning word selected");
  a_phase_offset: assert property (@(posedge clk) disable iff (sys_rst)
    run && advance |=> core_reset ||
      phase_r == $past(acc_r[dnco_pkg::ACC_W-1 -: dnco_pkg::PH_W]) +
                 $past(phase_sel ? phase_offset_b_r : phase_offset_a_r))
    else $error("phase offset sum wrong");
  a_ramp_path: assert property (@(posedge clk) disable iff (sys_rst)
    wave_ramp && !dig_en |-> amp_code == ramp_code)
    else $error("ramp mode used the sine table");
  a_sine_mid: assert property (@(posedge clk) disable iff (sys_rst)
    use_sine && phase_r == '0 |-> amp_code == dnco_pkg::MID_CODE)
    else $error("sine code at zero phase not midscale");
  a_cmp_gate: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 comparator_enable == ($past(dig_en && cmp_route) && !$past(core_reset)))
    else $error("comparator enable not gated by both bits");
  a_reset_mid: assert property (@(posedge clk) disable iff (sys_rst)
    core_reset |=> dac_data == dnco_pkg::MID_CODE && !dac_valid && acc_r == '0)
    else $error("core reset did not give midscale");
  a_regs_kept: assert property (@(posedge clk) disable iff (sys_rst)
    core_reset && !wr_done |=> $stable(tuning_word_a_r) && $stable(phase_offset_b_r)
      && $stable(ctrl_r))
    else $error("core reset disturbed a register");
  a_apb_answer: assert property (@(posedge clk) disable iff (sys_rst)
    psel && penable && !pready |=> pready)
    else $error("apb answer late");

  c_freq_switch: cover property (@(posedge clk) run && $changed(freq_sel));
  c_fifo_full: cover property (@(posedge clk) run && !fifo_in_ready);
  c_ramp_out: cover property (@(posedge clk) dac_valid && wave_ramp && !dig_en);
  c_acc_wrap: cover property (@(posedge clk) run && advance && acc_nxt < acc_r);
endmodule

// ===== dnco_dac_model.sv
// Converter-side sink model: takes amplitude samples, can stall
`timescale 1ns/10ps
module dnco_dac_model (
  // Clock
  input wire logic clk,
  // Sample stream from the core
  input wire logic [dnco_pkg::AMP_W-1:0] dac_data,
  input wire logic dac_valid,
  output logic dac_ready,
  // Bench side
  input wire logic stall,
  output logic got,
  output logic [dnco_pkg::AMP_W-1:0] got_data
);
  initial
  begin
    dac_ready = 1'b0;
    got = 1'b0;
    got_data = 10'h000;
  end
  // Ready only changes right after an edge
  always @(posedge clk)
  begin
    got <= dac_valid && dac_ready;
    got_data <= dac_data;
    dac_ready <= !stall;
  end
endmodule

// ===== dds_nco_phase_to_amplitude_tb.sv
// Self-checking bench for the oscillator core
`timescale 1ns/10ps
module dds_nco_phase_to_amplitude_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic core_reset = 1'b0;
  logic fpin = 1'b0;
  logic ppin = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] dac_data;
  logic dac_valid;
  logic dac_ready;
  logic msb_out;
  logic comparator_enable;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic got;
  logic [9:0] got_data;
  logic [9:0] q[$];
  int n_mismatch = 0;
  int compares = 0;

  always #5 clk = ~clk;

  dnco_core DUT (.clk(clk), .sys_rst(sys_rst), .core_reset(core_reset),
    .freq_choice_pin(fpin), .phase_choice_pin(ppin), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dac_data(dac_data), .dac_valid(dac_valid), .dac_ready(dac_ready),
    .msb_out(msb_out), .comparator_enable(comparator_enable));

  dnco_dac_model sink (.clk(clk), .dac_data(dac_data), .dac_valid(dac_valid),
    .dac_ready(dac_ready), .stall(stall), .got(got), .got_data(got_data));

  // Long random stalls let the buffer fill and push back
  always @(posedge clk)
  begin
    stall <= slow && ($urandom % 8 != 0);
    if (got)
      q.push_back(got_data);
  end

  task automatic finish_test;
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask

  // Parabolic sine approximation of the core, or ramp when bypassed
  function automatic logic [9:0] amp(input logic [11:0] ph, input logic ramp);
    int h;
    int v;
    h = ph[10:0];
    v = (h * (2048 - h)) >> 11;
    if (v > 511)
      v = 511;
    if (ramp)
      return ph[11] ? ~ph[10:1] : ph[10:1];
    return ph[11] ? 10'(512 - v) : 10'(512 + v);
  endfunction

  logic [31:0] rd;
  logic err;
  logic [11:0] s[2];
  logic [11:0] p[2];
  logic [6:0] ctrl;
  logic fb;
  logic pb;
  logic ok;
  logic any;
  int n;
  logic [6:0] cfg[8] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h30, 7'h60};

  initial
  begin
    void'($urandom(55476));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(dac_data, dnco_pkg::MID_CODE);
    chk(dac_valid, 1'b0);
    apb(1'b0, 8'h18, 32'h0, rd, err);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      core_reset <= 1'b1;
      ctrl = cfg[i];
      fpin <= $urandom;
      ppin <= $urandom;
      slow <= i[0];
      for (int k = 0; k < 2; k++)
      begin
        s[k] = (i == 7) ? 12'hfff : 12'($urandom);
        p[k] = 12'($urandom);
        apb(1'b1, k ? dnco_pkg::OFS_TUNE_B : dnco_pkg::OFS_TUNE_A, {4'h0, s[k], 16'h0}, rd, err);
        apb(1'b1, k ? dnco_pkg::OFS_PHASE_B : dnco_pkg::OFS_PHASE_A, {20'h0, p[k]}, rd, err);
      end
      apb(1'b1, dnco_pkg::OFS_CTRL, {25'h0, ctrl}, rd, err);
      apb(1'b0, dnco_pkg::OFS_TUNE_B, 32'h0, rd, err);
      chk(rd, {4'h0, s[1], 16'h0});
      // Held core reset leaves the accumulator and buffer level at zero
      apb(1'b0, dnco_pkg::OFS_STATUS, 32'h0, rd, err);
      chk(rd, 32'h0);
      chk(err, 1'b0);
      q.delete();
      @(posedge clk);
      core_reset <= 1'b0;
      n = 0;
      while (q.size() < 8 && n < 400)
      begin
        @(posedge clk);
        n++;
      end
      chk(n < 400, 1'b1);
      if (n >= 400)
        finish_test();
      fb = ctrl[1] ? fpin : ctrl[0];
      pb = ctrl[3] ? ppin : ctrl[2];
      any = 1'b0;
      // Start phase is 0 or a step or two in, depending on pipeline alignment
      for (int j = 0; j < 3; j++)
      begin
        ok = 1'b1;
        for (int k = 0; k < 8; k++)
          if (q[k] !== amp(12'((j + k) * s[fb]) + p[pb], ctrl[4] & !ctrl[5]))
            ok = 1'b0;
        any = any | ok;
      end
      chk(any, 1'b1);
      chk(comparator_enable, ctrl[5] & ctrl[6]);
      chk(msb_out & !(ctrl[5] & !ctrl[6]), 1'b0);
    end
    finish_test();
  end
endmodule
